// file: hdl/lane_pkg.sv
// Function
// - lane enables from size, offset, width
// - byte port uses only top lane
// - word port lanes by lowest address bit
// - long port lanes from offset onward
// - cachable read drives every attached lane
// - byte strobes are enables and data strobe, none on cachable reads
// - one port width per long word
// - cachable reads return full port width
// - burst slave is 32-bit, acknowledges burst
// - burst beats end with synchronous terminate
package lane_pkg;
  // transfer size codes {hi,lo}
  localparam logic [1:0] SIZE_LONG = 2'h0;
  localparam logic [1:0] SIZE_BYTE = 2'h1;
  localparam logic [1:0] SIZE_WORD = 2'h2;
  localparam logic [1:0] SIZE_TRIPLE = 2'h3;
  // port width setting
  localparam logic [1:0] PORT_8 = 2'h0;
  localparam logic [1:0] PORT_16 = 2'h1;
  localparam logic [1:0] PORT_32 = 2'h2;
  // port width acknowledge codes, active high
  localparam logic [1:0] ACK_8 = 2'h1;
  localparam logic [1:0] ACK_16 = 2'h2;
  localparam logic [1:0] ACK_32 = 2'h3;
  localparam logic [1:0] ACK_NONE = 2'h0;
  // lane groups, bit 3 is the top lane
  localparam logic [3:0] LANES_ALL = 4'hF;
  localparam logic [3:0] LANES_HALF = 4'hC;
  localparam logic [3:0] LANES_TOP = 4'h8;
  localparam logic [3:0] LANES_NONE = 4'h0;
  // storage and buffering
  localparam int MEM_AW = 4;
  localparam int MEM_WORDS = 16;
  localparam int FIFO_DEPTH = 4;
  localparam int FIFO_W = 40;
  localparam logic [1:0] LAST_BEAT = 2'h3;
  // register byte offsets
  localparam logic [3:0] REG_CTRL = 4'h0;
  localparam logic [3:0] REG_STATUS = 4'h4;
  localparam logic [3:0] REG_COUNT = 4'h8;
  // control fields and reset value
  localparam int CTRL_WIDTH_LSB = 0;
  localparam int CTRL_BURST_BIT = 2;
  localparam int CTRL_SYNC_BIT = 3;
  localparam int CTRL_HOLD_BIT = 4;
  localparam logic [4:0] CTRL_RESET = 5'h02;
  // status fields
  localparam int ST_LANES_LSB = 0;
  localparam int ST_EMPTY_BIT = 4;
  localparam int ST_FULL_BIT = 5;
  localparam int ST_BUSY_BIT = 6;
  // counter fields
  localparam int CNT_READ_LSB = 16;
  localparam logic [15:0] CNT_RESET = 16'h0000;
endpackage

// file: hdl/lane_slave_ctrl.sv
// Our own choices: the Wishbone register port and the register addresses.
`timescale 1ns/1ps
`default_nettype none
// slave port that answers the processor bus with dynamic sizing
module lane_slave_ctrl
  import lane_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  // wishbone register port
  input wire logic [3:0] wb_adr_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic wb_we_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // processor bus, same clock
  input wire logic ds_i,
  input wire logic rw_i,
  input wire logic cache_req_i,
  input wire logic burst_req_i,
  input wire logic xfer_size_hi_i,
  input wire logic xfer_size_lo_i,
  input wire logic addr_bit_one_i,
  input wire logic addr_bit_zero_i,
  input wire logic [MEM_AW-1:0] addr_word_i,
  input wire logic [31:0] data_i,
  output logic [31:0] data_o,
  output logic [3:0] data_oe_o,
  output logic [3:0] lane_strobe_o,
  output logic [1:0] port_width_ack_o,
  output logic sync_cycle_terminate_o,
  output logic cache_burst_ack_o
);
  typedef enum logic [5:0] {
    ST_IDLE = 6'h01,
    ST_WRITE = 6'h02,
    ST_RDWAIT = 6'h04,
    ST_RDMEM = 6'h08,
    ST_RDATA = 6'h10,
    ST_ACK = 6'h20
  } state_type;

  state_type state; // bus cycle sequencer
  logic [4:0] ctrl; // software settings
  logic [1:0] width; // port width from ctrl
  logic [1:0] width_q; // width held for the cycle
  logic sync_q; // cycle ends with sync terminate
  logic rw_q; // 1 = read
  logic cache_q; // cachable read
  logic burst_q; // burst accepted
  logic [1:0] off_q; // low address bits
  logic [MEM_AW-1:0] word_q; // word address
  logic [1:0] beat; // burst beat number
  logic [3:0] lane_en_q; // enables of the cycle
  logic [15:0] rd_count; // reads served
  logic [15:0] wr_count; // writes served
  logic [1:0] size_code; // {hi,lo}
  logic [1:0] off; // {a1,a0}
  logic [2:0] nbytes; // bytes requested
  logic [2:0] last; // offset of last byte
  logic [3:0] en32; // long port enables
  logic [3:0] en16; // word port enables
  logic [3:0] lane_en; // enables for chosen width
  logic [3:0] port_lanes; // every lane the port sits on
  logic [3:0] port_q; // lanes of the held port width
  logic [3:0] mem_be; // byte writes into storage
  logic [31:0] mem_wdata; // write data aligned to storage
  logic [31:0] rd_data; // storage read data
  logic [31:0] rd_map; // read data placed on the lanes
  logic rd_en; // storage read request
  logic [MEM_AW-1:0] rd_addr; // storage read address
  logic fifo_full;
  logic fifo_empty;
  logic push_done; // write entry taken by the fifo
  logic [1:0] ack_code; // width acknowledge for the cycle

  word_stream_if #(.W(FIFO_W)) push_s ();
  word_stream_if #(.W(FIFO_W)) drain_s ();

  assign width = ctrl[CTRL_WIDTH_LSB +: 2];
  assign size_code = {xfer_size_hi_i, xfer_size_lo_i};
  assign off = {addr_bit_one_i, addr_bit_zero_i};

  // byte count of the size code, long word is four
  assign nbytes = (size_code == SIZE_LONG) ? 3'h4 : {1'b0, size_code};
  assign last = {1'b0, off} + nbytes - 3'h1;

  // long port: lanes from the offset to the last byte, stop at 7:0
  for (genvar k = 0; k < 4; k++) begin : g_en32
    assign en32[3-k] = (3'(k) >= {1'b0, off}) && (3'(k) <= last);
  end

  // word port: top lane on even byte, next lane on odd or wider
  assign en16 = {!addr_bit_zero_i,
                 addr_bit_zero_i || (size_code != SIZE_BYTE),
                 2'b00};

  // pure decode, no state involved
  always_comb begin
    unique case (width)
      PORT_8: begin
        lane_en = LANES_TOP;
        port_lanes = LANES_TOP;
        mem_be = LANES_TOP >> off;
        mem_wdata = {4{data_i[31:24]}};
      end
      PORT_16: begin
        lane_en = en16;
        port_lanes = LANES_HALF;
        mem_be = addr_bit_one_i ? {2'b00, en16[3:2]} : en16;
        mem_wdata = {2{data_i[31:16]}};
      end
      default: begin
        lane_en = en32;
        port_lanes = LANES_ALL;
        mem_be = en32;
        mem_wdata = data_i;
      end
    endcase
  end

  // acknowledge code follows the held width for the whole word
  always_comb begin
    unique case (width_q)
      PORT_8: ack_code = ACK_8;
      PORT_16: ack_code = ACK_16;
      default: ack_code = ACK_32;
    endcase
  end

  // cached reads ignore size: byte port moves the addressed byte up,
  // word port gives the word holding it, long port the whole word
  always_comb begin
    unique case (width_q)
      PORT_8: rd_map = rd_data << {off_q, 3'h0};
      PORT_16: rd_map = off_q[1] ? {2{rd_data[15:0]}} : rd_data;
      default: rd_map = rd_data;
    endcase
  end

  // write entries wait in the fifo; a read first lets it run dry,
  // trading read latency for never returning stale bytes
  assign push_s.valid = (state == ST_WRITE);
  assign push_done = push_s.valid && push_s.ready;
  assign drain_s.ready = !ctrl[CTRL_HOLD_BIT];
  assign rd_en = ((state == ST_RDWAIT) && fifo_empty) ||
                 ((state == ST_RDATA) && burst_q && (beat != LAST_BEAT));
  assign rd_addr = (state == ST_RDATA)
                   ? {word_q[MEM_AW-1:2], word_q[1:0] + beat + 2'h1}
                   : word_q;

  word_fifo #(.W(FIFO_W), .D(FIFO_DEPTH)) u_fifo (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .fill_s(push_s),
    .drain_s(drain_s),
    .full_o(fifo_full),
    .empty_o(fifo_empty)
  );

  word_mem u_mem (
    .clk_i(clk_i),
    .wr_en_i(drain_s.valid && drain_s.ready),
    .wr_addr_i(drain_s.data[39:36]),
    .wr_be_i(drain_s.data[35:32]),
    .wr_data_i(drain_s.data[31:0]),
    .rd_en_i(rd_en),
    .rd_addr_i(rd_addr),
    .rd_data_o(rd_data)
  );

  // cycle sequencer
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state <= ST_IDLE;
    end else begin
      unique case (state)
        ST_IDLE: if (ds_i) state <= rw_i ? ST_RDWAIT : ST_WRITE;
        // a full fifo holds the cycle: back-pressure to the processor
        ST_WRITE: if (push_done) state <= ST_ACK;
        ST_RDWAIT: if (fifo_empty) state <= ST_RDMEM;
        ST_RDMEM: state <= ST_RDATA;
        // next beat wraps within the four-entry line
        ST_RDATA: state <= rd_en ? ST_RDMEM : ST_ACK;
        ST_ACK: if (!ds_i) state <= ST_IDLE;
        default: state <= ST_IDLE;
      endcase
    end
  end

  // cycle attributes caught at the data strobe
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rw_q <= 1'b0;
      cache_q <= 1'b0;
      burst_q <= 1'b0;
      off_q <= 2'h0;
      word_q <= '0;
      width_q <= PORT_32;
      port_q <= LANES_ALL;
      sync_q <= 1'b0;
      lane_en_q <= LANES_NONE;
      push_s.data <= '0;
    end else if ((state == ST_IDLE) && ds_i) begin
      rw_q <= rw_i;
      cache_q <= rw_i && cache_req_i;
      // bursts only on a 32-bit port ended synchronously
      burst_q <= rw_i && cache_req_i && burst_req_i &&
                 ctrl[CTRL_BURST_BIT] && ctrl[CTRL_SYNC_BIT] &&
                 (width == PORT_32);
      off_q <= off;
      word_q <= addr_word_i;
      width_q <= width;
      port_q <= port_lanes;
      sync_q <= ctrl[CTRL_SYNC_BIT];
      lane_en_q <= lane_en;
      push_s.data <= {addr_word_i, mem_be, mem_wdata};
    end
  end

  // beat counter of a burst
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      beat <= 2'h0;
    end else if (state == ST_IDLE) begin
      beat <= 2'h0;
    end else if ((state == ST_RDATA) && rd_en) begin
      beat <= beat + 2'h1;
    end
  end

  // per-byte strobes: enable and data strobe, writes and uncached reads
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      lane_strobe_o <= LANES_NONE;
    end else if (ds_i && (!rw_i || !cache_req_i)) begin
      lane_strobe_o <= lane_en;
    end else begin
      lane_strobe_o <= LANES_NONE;
    end
  end

  // read data and lane drive, held until the data strobe falls
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      data_o <= 32'h00000000;
      data_oe_o <= LANES_NONE;
    end else if (state == ST_RDMEM) begin
      data_o <= rd_map;
      // cached reads drive the whole port, others only selected lanes
      data_oe_o <= cache_q ? port_q : lane_en_q;
    end else if ((state == ST_ACK) && !ds_i) begin
      data_oe_o <= LANES_NONE;
    end
  end

  // terminations: width ack held to strobe end, sync terminate one pulse
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      port_width_ack_o <= ACK_NONE;
      sync_cycle_terminate_o <= 1'b0;
      cache_burst_ack_o <= 1'b0;
    end else begin
      sync_cycle_terminate_o <= sync_q && (push_done ||
                                           (state == ST_RDMEM));
      cache_burst_ack_o <= (state == ST_RDMEM) && burst_q &&
                           (beat == 2'h0);
      if (!sync_q && (push_done || (state == ST_RDMEM))) begin
        port_width_ack_o <= ack_code;
      end else if ((state == ST_ACK) && !ds_i) begin
        port_width_ack_o <= ACK_NONE;
      end
    end
  end

  // traffic counters
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rd_count <= CNT_RESET;
      wr_count <= CNT_RESET;
    end else if ((state == ST_IDLE) && ds_i) begin
      if (rw_i) begin
        rd_count <= rd_count + 16'h0001;
      end else begin
        wr_count <= wr_count + 16'h0001;
      end
    end
  end

  // wishbone slave: one wait-free ack, unmapped reads give zero
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h00000000;
      ctrl <= CTRL_RESET;
    end else begin
      wb_ack_o <= wb_cyc_i && wb_stb_i && !wb_ack_o;
      wb_dat_o <= 32'h00000000;
      if (wb_cyc_i && wb_stb_i && !wb_ack_o) begin
        if (wb_we_i && (wb_adr_i == REG_CTRL) && wb_sel_i[0]) begin
          ctrl <= wb_dat_i[4:0];
        end
        unique case (wb_adr_i)
          REG_CTRL: wb_dat_o <= {27'h0000000, ctrl};
          REG_STATUS: wb_dat_o <= {25'h0000000, (state != ST_IDLE),
                                   fifo_full, fifo_empty, lane_en_q};
          REG_COUNT: wb_dat_o <= {rd_count, wr_count};
          default: wb_dat_o <= 32'h00000000;
        endcase
      end
    end
  end

  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);

  a_byte_port_lane: assert property (
    (width == PORT_8) && $past(width == PORT_8) && (lane_strobe_o != 0)
    |-> lane_strobe_o == LANES_TOP)
    else $error("byte port strobed a lane other than the top one");
  a_word_port_lanes: assert property (
    $past(ds_i && (width == PORT_16) && !addr_bit_zero_i && !rw_i &&
          (size_code != SIZE_BYTE)) |-> lane_strobe_o == LANES_HALF)
    else $error("word port write did not strobe both upper lanes");
  a_long_lanes_end: assert property (
    $past(ds_i && (width == PORT_32) && !rw_i && (size_code == SIZE_LONG))
    |-> lane_strobe_o[0] && (lane_strobe_o[3] == ($past(off) == 2'h0)))
    else $error("long port long-word lanes wrong");
  a_strobe_gated: assert property (
    (lane_strobe_o != 0) |-> $past(ds_i) && !($past(rw_i && cache_req_i)))
    else $error("strobe without data strobe or on cachable read");
  a_cache_all_lanes: assert property (
    (state == ST_RDMEM) && cache_q && (width_q == PORT_32)
    |=> data_oe_o == LANES_ALL)
    else $error("cachable read did not drive all port lanes");
  a_ack_matches_width: assert property (
    (port_width_ack_o != ACK_NONE) |-> (port_width_ack_o == ack_code)
    && $stable(width_q))
    else $error("width acknowledge differs from held port width");
  a_burst_only_long: assert property (
    cache_burst_ack_o |-> (width_q == PORT_32) && sync_cycle_terminate_o)
    else $error("burst acknowledged on a narrow port");
  a_burst_beats: assert property (
    cache_burst_ack_o |-> ##2 sync_cycle_terminate_o
    ##2 sync_cycle_terminate_o ##2 sync_cycle_terminate_o)
    else $error("burst did not deliver four terminated beats");
  a_cache_no_strobe: assert property (
    $past(ds_i && rw_i && cache_req_i) |-> lane_strobe_o == LANES_NONE)
    else $error("cachable read produced byte strobes");
  c_burst: cover property (cache_burst_ack_o);
  c_fifo_full: cover property (fifo_full && (state == ST_WRITE));
  c_byte_write: cover property ((width_q == PORT_8) && push_done);
  c_word_cache: cover property ((width_q == PORT_16) && cache_q &&
                                (state == ST_RDATA));
endmodule
`default_nettype wire

// file: hdl/word_fifo.sv
`timescale 1ns/1ps
`default_nettype none
// small synchronous fifo, full and empty from an occupancy count
module word_fifo #(
  parameter int W = 40,
  parameter int D = 4
) (
  input wire logic clk_i,
  input wire logic rst_i,
  word_stream_if.sink fill_s,
  word_stream_if.source drain_s,
  output logic full_o,
  output logic empty_o
);
  localparam int PW = $clog2(D);
  logic [W-1:0] store [D]; // entries, no reset needed
  logic [PW-1:0] wr_ptr; // next slot to fill
  logic [PW-1:0] rd_ptr; // oldest entry
  logic [PW:0] count; // occupancy
  logic push;
  logic pop;

  assign push = fill_s.valid && fill_s.ready;
  assign pop = drain_s.valid && drain_s.ready;
  assign fill_s.ready = (count != (PW+1)'(D));
  assign drain_s.valid = (count != '0);
  assign drain_s.data = store[rd_ptr];
  assign full_o = !fill_s.ready;
  assign empty_o = !drain_s.valid;

  // storage write, no reset to keep it ram-like
  always_ff @(posedge clk_i) begin
    if (push) begin
      store[wr_ptr] <= fill_s.data;
    end
  end

  // pointers wrap at depth, depth need not be a power of two
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
    end else begin
      if (push) begin
        wr_ptr <= (wr_ptr == PW'(D-1)) ? '0 : wr_ptr + 1'b1;
      end
      if (pop) begin
        rd_ptr <= (rd_ptr == PW'(D-1)) ? '0 : rd_ptr + 1'b1;
      end
    end
  end

  // occupancy
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      count <= '0;
    end else if (push && !pop) begin
      count <= count + 1'b1;
    end else if (pop && !push) begin
      count <= count - 1'b1;
    end
  end
endmodule
`default_nettype wire

// file: hdl/word_mem.sv
`timescale 1ns/1ps
`default_nettype none
// word store with per-byte write enables, registered read data
module word_mem
  import lane_pkg::*;
(
  input wire logic clk_i,
  input wire logic wr_en_i,
  input wire logic [MEM_AW-1:0] wr_addr_i,
  input wire logic [3:0] wr_be_i,
  input wire logic [31:0] wr_data_i,
  input wire logic rd_en_i,
  input wire logic [MEM_AW-1:0] rd_addr_i,
  output logic [31:0] rd_data_o
);
  // one byte-wide store per lane, so every array has a single writer;
  // lane 3 (bits 31:24) holds byte offset 0
  for (genvar b = 0; b < 4; b++) begin : g_lane
    logic [7:0] cells [MEM_WORDS]; // lane b of every word
    always_ff @(posedge clk_i) begin
      if (wr_en_i && wr_be_i[b]) begin
        cells[wr_addr_i] <= wr_data_i[8*b +: 8];
      end
    end

    // read data one cycle after the request
    always_ff @(posedge clk_i) begin
      if (rd_en_i) begin
        rd_data_o[8*b +: 8] <= cells[rd_addr_i];
      end
    end
  end
endmodule
`default_nettype wire

// file: hdl/word_stream_if.sv
`timescale 1ns/1ps
`default_nettype none
// valid/ready word stream between the top and the fifo
interface word_stream_if #(parameter int W = 40) ();
  logic valid; // word offered
  logic ready; // word accepted
  logic [W-1:0] data; // payload
  modport source(output valid, output data, input ready);
  modport sink(input valid, input data, output ready);
endinterface
`default_nettype wire

// file: testbench/cpu_model.sv
`timescale 1ns/1ps
`default_nettype none
// processor side of the bus, one bus cycle per call
module cpu_model
  import lane_pkg::*;
(
  input wire logic clk_i,
  input wire logic [31:0] rd_data_i,
  input wire logic [3:0] oe_i,
  input wire logic [3:0] strobe_i,
  input wire logic [1:0] width_ack_i,
  input wire logic term_i,
  input wire logic burst_ack_i,
  output logic ds_o,
  output logic rw_o,
  output logic cache_req_o,
  output logic burst_req_o,
  output logic [1:0] size_o,
  output logic [1:0] offset_o,
  output logic [3:0] word_o,
  output logic [31:0] wr_data_o
);
  logic [31:0] beat_q [4]; // data taken per beat
  logic [1:0] ack_q; // width code seen
  logic cbk_q; // burst acknowledge seen
  logic [3:0] stb_q; // strobes at the answer
  logic [3:0] oe_q; // drive enables at the answer
  logic ok; // low when an answer never came

  // bus idle at time zero
  initial begin
    {ds_o, rw_o, cache_req_o, burst_req_o} = 4'h0;
    {size_o, offset_o, word_o} = 8'h00;
    wr_data_o = 32'h0000_0000;
    ok = 1'b1;
  end

  // request held until the answer edge, then released
  task automatic xfer(input logic rd, input logic [1:0] sz,
                      input logic [1:0] off, input logic [3:0] wa,
                      input logic [31:0] wd, input logic cch,
                      input logic bst, input int beats);
    int n;
    ok = 1'b1;
    cbk_q = 1'b0;
    @(posedge clk_i);
    ds_o <= 1'b1;
    rw_o <= rd;
    size_o <= sz;
    offset_o <= off;
    word_o <= wa;
    cache_req_o <= cch;
    burst_req_o <= bst;
    wr_data_o <= wd;
    // a burst waits for one answer per beat, as many as the caller gives in beats
    // a refused burst ends as a plain cycle, with a width acknowledge, or a sync terminate when sync is set
    for (int b = 0; b < beats; b++) begin
      n = 0;
      do begin
        @(posedge clk_i);
        n++;
      end while (width_ack_i === 2'h0 && term_i !== 1'b1 && n < 40);
      if (n >= 40) ok = 1'b0;
      beat_q[b] = rd_data_i;
      ack_q = width_ack_i;
      cbk_q = cbk_q | burst_ack_i;
      stb_q = strobe_i;
      oe_q = oe_i;
    end
    ds_o <= 1'b0;
    // released bus shows a changed value, not the old one
    wr_data_o <= ~wd;
    n = 0;
    do begin
      @(posedge clk_i);
      n++;
    end while (width_ack_i !== 2'h0 && n < 40);
    if (n >= 40) ok = 1'b0;
    repeat (2) @(posedge clk_i);
  endtask
endmodule
`default_nettype wire

// file: testbench/testbench.sv
`timescale 1ns/1ps
`default_nettype none
// self-checking bench for the dynamically sized slave port
module testbench;
  import lane_pkg::*;
  logic clk_i, rst_i;
  logic [3:0] wb_adr, wb_sel;
  logic [31:0] wb_wdat, wb_rdat, q;
  logic wb_we, wb_cyc, wb_stb, wb_ack;
  logic ds, rw, cache_req, burst_req, term, cache_burst_ack;
  logic [1:0] size, offset, wack;
  logic [3:0] word, oe, strobe;
  logic [31:0] wdata, rdata;
  int miscompares, n_compared;

  lane_slave_ctrl u_lane_slave_ctrl (.clk_i(clk_i), .rst_i(rst_i),
    .wb_adr_i(wb_adr), .wb_dat_i(wb_wdat), .wb_sel_i(wb_sel),
    .wb_we_i(wb_we), .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb),
    .wb_dat_o(wb_rdat), .wb_ack_o(wb_ack), .ds_i(ds), .rw_i(rw),
    .cache_req_i(cache_req), .burst_req_i(burst_req),
    .xfer_size_hi_i(size[1]), .xfer_size_lo_i(size[0]),
    .addr_bit_one_i(offset[1]), .addr_bit_zero_i(offset[0]),
    .addr_word_i(word), .data_i(wdata), .data_o(rdata),
    .data_oe_o(oe), .lane_strobe_o(strobe), .port_width_ack_o(wack),
    .sync_cycle_terminate_o(term), .cache_burst_ack_o(cache_burst_ack));

  cpu_model u_cpu_model (.clk_i(clk_i), .rd_data_i(rdata), .oe_i(oe),
    .strobe_i(strobe), .width_ack_i(wack), .term_i(term),
    .burst_ack_i(cache_burst_ack), .ds_o(ds), .rw_o(rw), .cache_req_o(cache_req),
    .burst_req_o(burst_req), .size_o(size), .offset_o(offset),
    .word_o(word), .wr_data_o(wdata));

  // free-running 50 MHz clock
  initial begin
    clk_i = 1'b0;
    forever #10 clk_i = ~clk_i;
  end

  // verdict and end of run
  task automatic close_out();
    $display("compared %0d mismatches %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] seen,
                     input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
      miscompares++;
    end
  endtask

  // classic single wishbone cycle, read data left in q
  task automatic wb(input logic [3:0] a, input logic we,
                    input logic [31:0] d);
    int n;
    @(posedge clk_i);
    wb_adr <= a;
    wb_we <= we;
    wb_wdat <= d;
    wb_sel <= 4'hF;
    wb_cyc <= 1'b1;
    wb_stb <= 1'b1;
    n = 0;
    do begin
      @(posedge clk_i);
      n++;
    end while (wb_ack !== 1'b1 && n < 20);
    q = wb_rdat;
    wb_cyc <= 1'b0;
    wb_stb <= 1'b0;
    wb_we <= 1'b0;
    if (n >= 20) begin miscompares++; close_out(); end
  endtask

  // one processor cycle, a lost answer ends the run
  task automatic cyc(input logic rd, input logic [1:0] sz, off,
                     input logic [3:0] wa, input logic [31:0] wd,
                     input logic cch, bst, input int beats);
    u_cpu_model.xfer(rd, sz, off, wa, wd, cch, bst, beats);
    if (u_cpu_model.ok !== 1'b1) begin miscompares++; close_out(); end
  endtask

  // expected lane enables for width, size code and offset
  function automatic logic [3:0] lanes(input int w, sz, off);
    logic [3:0] m;
    int n;
    if (w == 0) return LANES_TOP;
    if (w == 1) return off[0] ? 4'h4 : (sz == 1 ? 4'h8 : 4'hC);
    n = (sz == 0) ? 4 : sz;
    m = 4'h0;
    for (int i = off; i < 4 && i < off + n; i++) m[3 - i] = 1'b1;
    return m;
  endfunction

  // register defaults and the unmapped hole
  task automatic t_reset();
    wb(REG_CTRL, 1'b0, 32'h0);
    chk("ctrl reset", q, 32'(CTRL_RESET));
    wb(REG_COUNT, 1'b0, 32'h0);
    chk("count reset", q, 32'h0);
    wb(4'hC, 1'b1, 32'hFFFF_FFFF);
    wb(4'hC, 1'b0, 32'h0);
    chk("unmapped", q, 32'h0);
  endtask

  // every width, size code and offset, write then uncached read
  task automatic t_lanes();
    logic [3:0] e;
    for (int w = 0; w < 3; w++) begin
      wb(REG_CTRL, 1'b1, 32'(w));
      for (int s = 0; s < 4; s++) for (int o = 0; o < 4; o++) begin
        e = lanes(w, s, o);
        cyc(1'b0, 2'(s), 2'(o), 4'h1, 32'h1122_3344, 1'b0, 1'b0, 1);
        if (w == 0) chk("lanes8", 32'(u_cpu_model.stb_q), 32'(e));
        if (w == 1) chk("lanes16", 32'(u_cpu_model.stb_q), 32'(e));
        if (w == 2) chk("lanes32", 32'(u_cpu_model.stb_q), 32'(e));
        chk("width ack", 32'(u_cpu_model.ack_q), 32'(w + 1));
        cyc(1'b1, 2'(s), 2'(o), 4'h1, 32'h0, 1'b0, 1'b0, 1);
        chk("read oe", 32'(u_cpu_model.oe_q), 32'(e));
        chk("read strobe", 32'(u_cpu_model.stb_q), 32'(e));
      end
    end
    wb(REG_STATUS, 1'b0, 32'h0);
    chk("status lanes", 32'(q[3:0]), 32'(e));
  endtask

  // cached reads ignore size, burst not granted
  task automatic t_cached();
    logic [3:0] e;
    logic [31:0] m;
    logic [31:0] x;
    wb(REG_CTRL, 1'b1, 32'h2);
    cyc(1'b0, SIZE_LONG, 2'h0, 4'h2, 32'hCAFE_0102, 1'b0, 1'b0, 1);
    for (int w = 0; w < 3; w++) begin
      e = (w == 0) ? LANES_TOP : (w == 1) ? LANES_HALF : LANES_ALL;
      m = {{8{e[3]}}, {8{e[2]}}, {8{e[1]}}, {8{e[0]}}};
      // byte port: addressed byte on top; word port: lower word boundary
      x = (w == 0) ? 32'h0200_0000 :
          (w == 1) ? 32'h0102_0000 : 32'hCAFE_0102;
      wb(REG_CTRL, 1'b1, 32'(w));
      cyc(1'b1, SIZE_BYTE, 2'h3, 4'h2, 32'h0, 1'b1, 1'b1, 1);
      chk("cached oe", 32'(u_cpu_model.oe_q), 32'(e));
      chk("cached ack", 32'(u_cpu_model.ack_q), 32'(w + 1));
      chk("no burst", 32'(u_cpu_model.cbk_q), 32'h0);
      chk("cached data", u_cpu_model.beat_q[0] & m, x);
    end
  endtask

  // four-beat burst starting mid-line, addresses wrap
  task automatic t_burst();
    logic [31:0] x;
    wb(REG_CTRL, 1'b1, 32'hE);
    for (int k = 0; k < 4; k++)
      cyc(1'b0, SIZE_LONG, 2'h0, 4'(4 + k), 32'hB000_0000 | k,
          1'b0, 1'b0, 1);
    cyc(1'b1, SIZE_LONG, 2'h0, 4'h5, 32'h0, 1'b1, 1'b1, 4);
    chk("burst ack", 32'(u_cpu_model.cbk_q), 32'h1);
    for (int b = 0; b < 4; b++) begin
      x = 32'hB000_0000 | 32'((b + 1) % 4);
      chk("burst beat", u_cpu_model.beat_q[b], x);
    end
  endtask

  // fifo filled while draining is held, fifth write stalls
  task automatic t_fifo();
    int n;
    wb(REG_CTRL, 1'b1, 32'h12);
    for (int k = 0; k < 4; k++)
      cyc(1'b0, SIZE_LONG, 2'h0, 4'(8 + k), 32'hD000_0000 | k,
          1'b0, 1'b0, 1);
    wb(REG_STATUS, 1'b0, 32'h0);
    chk("fifo full", 32'(q[ST_FULL_BIT]), 32'h1);
    fork
      cyc(1'b0, SIZE_LONG, 2'h0, 4'hC, 32'hD000_0004, 1'b0, 1'b0, 1);
      begin
        repeat (10) @(negedge clk_i);
        chk("stalled ack", 32'(wack), 32'h0);
        wb(REG_CTRL, 1'b1, 32'h2);
      end
    join
    n = 0;
    do begin
      wb(REG_STATUS, 1'b0, 32'h0);
      n++;
    end while (q[ST_EMPTY_BIT] !== 1'b1 && n < 20);
    chk("fifo empty", 32'(q[ST_EMPTY_BIT]), 32'h1);
    cyc(1'b1, SIZE_LONG, 2'h0, 4'hC, 32'h0, 1'b0, 1'b0, 1);
    chk("drained word", u_cpu_model.beat_q[0], 32'hD000_0004);
  endtask

  // main sequence
  initial begin
    rst_i = 1'b1;
    {wb_adr, wb_sel, wb_we, wb_cyc, wb_stb} = 11'h000;
    wb_wdat = 32'h0;
    miscompares = 0;
    n_compared = 0;
    repeat (20) @(posedge clk_i);
    rst_i <= 1'b0;
    t_reset();
    t_lanes();
    t_cached();
    t_burst();
    t_fifo();
    close_out();
  end

  // hang guard
  initial begin
    repeat (60000) @(posedge clk_i);
    miscompares++;
    close_out();
  end
endmodule
`default_nettype wire
